// ### hw/adcr_pkg.sv
// shared constants and types of the converter serial target
package adcr_pkg;
	localparam int             RES_W       = 10;          // conversion result width
	localparam int             FIFO_DEPTH  = 32;          // result buffer depth
	localparam logic [3:0]     ADDR_BITS   = 4'h8;        // bits in the address byte
	localparam logic [3:0]     BIT_LAST    = 4'h7;        // last bit index of a byte
	localparam logic [3:0]     HI_PAD      = 4'h0;        // leading zeros of the upper byte
	localparam logic [1:0]     LO_PAD      = 2'h0;        // don't-care tail of the lower byte
	localparam logic [3:0]     CNT_ZERO    = 4'h0;        // counter restart value
	localparam logic [3:0]     CNT_ONE     = 4'h1;        // counter step
	localparam logic [3:0]     PAD_BITS    = 4'h4;        // zero bits leading the upper byte
	localparam logic [3:0]     TAIL_FIRST  = 4'h6;        // first don't-care bit of the lower byte
	localparam logic [3:0]     DEV_CODE    = 4'h5;        // device code, value is arbitrary

	// one-hot link states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_AACK = 5'h04,
		ST_TXD  = 5'h08,
		ST_RACK = 5'h10
	} adcr_state_t;
endpackage : adcr_pkg

// ### hw/adcr_fifo.sv
// parameterised result buffer with valid and ready on both sides
`timescale 1ns/10ps
module adcr_fifo #(
	parameter int W = 10,
	parameter int D = 32
) (
	input  wire logic         mclk_i,       // system clock
	input  wire logic         srst_i,       // synchronous reset
	input  wire logic         flush_i,      // drop all stored words
	input  wire logic         in_valid_i,   // word offered
	output logic              in_ready_o,   // room for a word
	input  wire logic [W-1:0] in_data_i,    // word in
	output logic              out_valid_o,  // word available
	input  wire logic         out_ready_i,  // word taken
	output logic      [W-1:0] out_data_o    // oldest word
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ptr_reg;
	logic [AW:0]  rd_ptr_reg;
	logic         push;
	logic         pop;

	// full when pointers differ only in the wrap bit
	assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
	assign in_ready_o  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign push        = in_valid_i && in_ready_o && !flush_i;
	assign pop         = out_valid_o && out_ready_i && !flush_i;
	assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];

	// storage has no reset, pointers alone define content
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	// pointers; flush wins over traffic in the same cycle
	always_ff @(posedge mclk_i) begin
		if (srst_i || flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
			end
		end
	end
endmodule : adcr_fifo

// ### hw/adcr_i2c_target.sv
// two-wire serial read target of a 10-bit converter
`timescale 1ns/10ps
module adcr_i2c_target (
	input  wire logic                        mclk_i,              // 100 MHz clock
	input  wire logic                        srst_i,              // sync reset, high
	input  wire logic                        scl_i,               // serial clock pin
	input  wire logic                        sda_i,               // data pin level
	output logic                             sda_o,               // data pin drive value
	output logic                             sda_oe_o,            // data pin pulled low
	input  wire logic                        address_select_bit2_i, // select strap
	input  wire logic                        address_select_bit1_i, // select strap
	input  wire logic                        address_select_bit0_i, // select strap
	output logic                             conv_start_o,        // sample and convert pulse
	input  wire logic                        conv_valid_i,        // converter result ready
	output logic                             conv_ready_o,        // buffer can take result
	input  wire logic [adcr_pkg::RES_W-1:0]  conv_data_i          // converter result
);
	adcr_pkg::adcr_state_t          state_reg;
	logic [2:0]                     scl_sync_reg;
	logic [2:0]                     sda_sync_reg;
	logic                           scl_f_reg;
	logic                           sda_f_reg;
	logic                           scl_q_reg;
	logic                           sda_q_reg;
	logic [2:0]                     sel_s1_reg;
	logic [2:0]                     sel_s2_reg;
	logic [2:0]                     sel_s3_reg;
	logic [2:0]                     sel_f_reg;
	logic [3:0]                     bitcnt_reg;
	logic [7:0]                     shift_reg;
	logic                           rw_reg;
	logic                           ack_reg;
	logic                           byte_lo_reg;
	logic [adcr_pkg::RES_W-1:0]     res_reg;
	logic [adcr_pkg::RES_W-1:0]     res_next;
	logic                           scl_rise;
	logic                           scl_fall;
	logic                           start_det;
	logic                           stop_det;
	logic                           addr_match;
	logic                           addr_done;
	logic                           pop;
	logic                           load_hi;
	logic                           load_lo;
	logic                           fifo_valid;
	logic [adcr_pkg::RES_W-1:0]     fifo_data;

	// three-stage pin sync; filtered level moves only when stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg    <= 1'b1;
			sda_f_reg    <= 1'b1;
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_f_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_f_reg <= sda_sync_reg[2];
			end
			scl_q_reg <= scl_f_reg;
			sda_q_reg <= sda_f_reg;
		end
	end

	// straps are pins as well; a change counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sel_s1_reg <= '0;
			sel_s2_reg <= '0;
			sel_s3_reg <= '0;
			sel_f_reg  <= '0;
		end else begin
			sel_s1_reg <= {address_select_bit2_i, address_select_bit1_i, address_select_bit0_i};
			sel_s2_reg <= sel_s1_reg;
			sel_s3_reg <= sel_s2_reg;
			if (sel_s2_reg == sel_s3_reg) begin
				sel_f_reg <= sel_s3_reg;
			end
		end
	end

	// bus events from the filtered levels
	assign scl_rise  = scl_f_reg && !scl_q_reg;
	assign scl_fall  = !scl_f_reg && scl_q_reg;
	assign start_det = scl_f_reg && scl_q_reg && sda_q_reg && !sda_f_reg;
	assign stop_det  = scl_f_reg && scl_q_reg && !sda_q_reg && sda_f_reg;

	// address compare against code and filtered straps
	assign addr_match = (shift_reg[7:4] == adcr_pkg::DEV_CODE) &&
		(shift_reg[3:1] == sel_f_reg);
	assign addr_done  = (state_reg == adcr_pkg::ST_ADDR) && scl_fall &&
		(bitcnt_reg == adcr_pkg::ADDR_BITS);

	// sampling starts on the edge ending the read bit or the lower byte's last bit
	assign conv_start_o = (addr_done && addr_match && shift_reg[0]) ||
		((state_reg == adcr_pkg::ST_TXD) && byte_lo_reg && scl_fall &&
		(bitcnt_reg == adcr_pkg::BIT_LAST));

	// a new result is taken as the upper byte is loaded
	assign load_hi = scl_fall && (((state_reg == adcr_pkg::ST_AACK) && rw_reg) ||
		((state_reg == adcr_pkg::ST_RACK) && ack_reg && byte_lo_reg));
	assign load_lo = scl_fall && (state_reg == adcr_pkg::ST_RACK) && ack_reg && !byte_lo_reg;
	assign pop      = load_hi;
	assign res_next = fifo_valid ? fifo_data : res_reg;

	// open drain: only ever pull low; zero bits and acks pull
	assign sda_o    = 1'b0;
	assign sda_oe_o = (state_reg == adcr_pkg::ST_AACK) ||
		((state_reg == adcr_pkg::ST_TXD) && !shift_reg[7]);

	// link state; stop beats start beats bit traffic
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_reg <= adcr_pkg::ST_IDLE;
		end else if (stop_det) begin
			state_reg <= adcr_pkg::ST_IDLE;
		end else if (start_det) begin
			state_reg <= adcr_pkg::ST_ADDR;
		end else begin
			unique case (state_reg)
				adcr_pkg::ST_IDLE: begin
				end
				adcr_pkg::ST_ADDR: begin
					if (addr_done) begin
						state_reg <= addr_match ? adcr_pkg::ST_AACK : adcr_pkg::ST_IDLE;
					end
				end
				adcr_pkg::ST_AACK: begin
					if (scl_fall) begin
						state_reg <= rw_reg ? adcr_pkg::ST_TXD : adcr_pkg::ST_IDLE;
					end
				end
				adcr_pkg::ST_TXD: begin
					if (scl_fall && bitcnt_reg == adcr_pkg::BIT_LAST) begin
						state_reg <= adcr_pkg::ST_RACK;
					end
				end
				adcr_pkg::ST_RACK: begin
					if (scl_fall) begin
						state_reg <= ack_reg ? adcr_pkg::ST_TXD : adcr_pkg::ST_IDLE;
					end
				end
				default: state_reg <= adcr_pkg::ST_IDLE;
			endcase
		end
	end

	// bit counter: rising edges in address, falling edges in transmit
	always_ff @(posedge mclk_i) begin
		if (srst_i || start_det) begin
			bitcnt_reg <= adcr_pkg::CNT_ZERO;
		end else if (state_reg == adcr_pkg::ST_ADDR && scl_rise) begin
			bitcnt_reg <= bitcnt_reg + adcr_pkg::CNT_ONE;
		end else if (state_reg == adcr_pkg::ST_TXD && scl_fall) begin
			bitcnt_reg <= bitcnt_reg + adcr_pkg::CNT_ONE;
		end else if (load_hi || load_lo) begin
			bitcnt_reg <= adcr_pkg::CNT_ZERO;
		end
	end

	// shifter: in msb first on rise, out msb first on fall
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			shift_reg <= 8'hFF;
		end else if (state_reg == adcr_pkg::ST_ADDR && scl_rise) begin
			shift_reg <= {shift_reg[6:0], sda_f_reg};
		end else if (load_hi) begin
			shift_reg <= {adcr_pkg::HI_PAD, res_next[9:6]};
		end else if (load_lo) begin
			shift_reg <= {res_reg[5:0], adcr_pkg::LO_PAD};
		end else if (state_reg == adcr_pkg::ST_TXD && scl_fall) begin
			shift_reg <= {shift_reg[6:0], 1'b1};                                   // released after last bit
		end
	end

	// direction, master ack and byte select
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rw_reg      <= 1'b0;
			ack_reg     <= 1'b0;
			byte_lo_reg <= 1'b0;
		end else begin
			if (addr_done) begin
				rw_reg <= shift_reg[0];
			end
			if (state_reg == adcr_pkg::ST_RACK && scl_rise) begin
				ack_reg <= !sda_f_reg;
			end
			if (load_hi) begin
				byte_lo_reg <= 1'b0;
			end else if (load_lo) begin
				byte_lo_reg <= 1'b1;
			end
		end
	end

	// whole result latched at once; empty buffer repeats the last result
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			res_reg <= '0;
		end else if (pop) begin
			res_reg <= res_next;
		end
	end

	// flushed at each sample so only the fresh result is read
	adcr_fifo #(
		.W (adcr_pkg::RES_W),
		.D (adcr_pkg::FIFO_DEPTH)
	) u_fifo (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.flush_i     (conv_start_o),
		.in_valid_i  (conv_valid_i),
		.in_ready_o  (conv_ready_o),
		.in_data_i   (conv_data_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_data)
	);

	// checks
	start_on_fall_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		conv_start_o |-> scl_fall) else $error("conversion start off a falling edge");
	read_ack_low_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(addr_done && addr_match && shift_reg[0] && !stop_det && !start_det)
		|=> sda_oe_o && conv_start_o == 1'b0) else $error("read address not acknowledged");
	idle_released_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		state_reg == adcr_pkg::ST_IDLE |-> !sda_oe_o) else $error("idle target pulls data");
	hi_zero_pad_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_TXD && !byte_lo_reg && bitcnt_reg < adcr_pkg::PAD_BITS)
		|-> sda_oe_o) else $error("upper byte pad bit not zero");
	lo_tail_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_TXD && byte_lo_reg && bitcnt_reg >= adcr_pkg::TAIL_FIRST)
		|-> sda_oe_o) else $error("lower byte tail not driven zero");
	poll_release_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_AACK && !rw_reg && scl_fall && !stop_det && !start_det)
		|=> state_reg == adcr_pkg::ST_IDLE && !sda_oe_o) else $error("poll did not release");
	addr_miss_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(addr_done && !addr_match && !stop_det && !start_det)
		|=> state_reg == adcr_pkg::ST_IDLE [*2]) else $error("foreign address answered");
	cont_sample_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_TXD && byte_lo_reg && scl_fall &&
		bitcnt_reg == adcr_pkg::BIT_LAST) |-> conv_start_o) else $error("no continuous sample");
	cont_next_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_RACK && byte_lo_reg && ack_reg && scl_fall && !stop_det &&
		!start_det) |=> state_reg == adcr_pkg::ST_TXD && !byte_lo_reg) else $error("no repeat");
	result_held_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_reg == adcr_pkg::ST_TXD && !load_hi) |=> $stable(res_reg))
		else $error("result changed mid transfer");
	read_cv: cover property (@(posedge mclk_i) disable iff (srst_i)
		state_reg == adcr_pkg::ST_RACK && byte_lo_reg && !ack_reg && scl_fall);
	cont_cv: cover property (@(posedge mclk_i) disable iff (srst_i)
		load_hi && state_reg == adcr_pkg::ST_RACK);
	poll_cv: cover property (@(posedge mclk_i) disable iff (srst_i)
		state_reg == adcr_pkg::ST_AACK && !rw_reg && scl_fall);
endmodule : adcr_i2c_target

// ### bench/adcr_i2c_master_model.sv
// behavioural two-wire bus controller driving the converter target
`timescale 1ns/10ps
module adcr_i2c_master_model (
	input  wire logic sda_i,    // resolved data line level
	output logic      scl_o,    // serial clock, stands high between frames
	output logic      sda_oe_o  // high pulls the data line low
);
	parameter real QTR = 31.25; // quarter of a 125 ns bit slot

	// idle bus: both lines released to the pull-ups
	initial begin
		scl_o    = 1'b1;
		sda_oe_o = 1'b0;
	end

	// data changes mid low phase, so the target never sees it move with clock high
	task automatic bit_x(input logic b, output logic r);
		#QTR sda_oe_o = ~b;
		#QTR scl_o = 1'b1;
		#QTR r = sda_i;
		#QTR scl_o = 1'b0;
	endtask : bit_x

	// one byte, most significant bit first
	task automatic byte_x(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			bit_x(w[i], r[i]);
		end
	endtask : byte_x

	// start or repeated start; extra wait lets the target let go of an ack first
	task automatic start_c();
		#QTR sda_oe_o = 1'b0;
		#(2 * QTR) scl_o = 1'b1;
		#QTR sda_oe_o = 1'b1;
		#QTR scl_o = 1'b0;
	endtask : start_c

	// stop leaves the clock standing high
	task automatic stop_c();
		#QTR sda_oe_o = 1'b1;
		#QTR scl_o = 1'b1;
		#QTR sda_oe_o = 1'b0;
		#QTR;
	endtask : stop_c
endmodule : adcr_i2c_master_model

// ### bench/test_adcr_i2c_target.sv
// self-checking bench of the converter serial target
`timescale 1ns/10ps
module test_adcr_i2c_target;
	logic        mclk_i;
	logic        srst_i      = 1'b1;
	logic [2:0]  strap       = 3'h0;
	logic        conv_valid_i = 1'b0;
	logic [9:0]  conv_data_i = 10'h000;
	logic        conv_start_o, conv_ready_o, sda_o, sda_oe, scl, m_oe, fill = 1'b0;
	wire         sda_line    = (m_oe | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
	logic [9:0]  last_res    = 10'h000;
	int          starts = 0, acc = 0, wait_c = 0, cyc = 0, error_cnt = 0, check_count = 0;

	adcr_i2c_target DUT (.mclk_i(mclk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .address_select_bit2_i(strap[2]),
		.address_select_bit1_i(strap[1]), .address_select_bit0_i(strap[0]),
		.conv_start_o(conv_start_o), .conv_valid_i(conv_valid_i),
		.conv_ready_o(conv_ready_o), .conv_data_i(conv_data_i));
	adcr_i2c_master_model master (.sda_i(sda_line), .scl_o(scl), .sda_oe_o(m_oe));

	// system clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// converter model: random latency well inside one bit time, result held until taken
	always @(posedge mclk_i) begin
		cyc++;
		if (conv_start_o) starts++;
		if (conv_start_o) wait_c <= $urandom_range(6, 2);
		else if (wait_c > 1) wait_c <= wait_c - 1;
		else if (wait_c == 1 || fill) begin
			wait_c       <= 0;
			conv_valid_i <= 1'b1;
		end
		if (conv_valid_i && conv_ready_o) begin
			last_res     <= conv_data_i;
			acc++;
			conv_data_i  <= 10'($urandom);
			conv_valid_i <= fill;
		end
		if (srst_i) conv_valid_i <= 1'b0;
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic addr_tx(input logic [7:0] ab, output logic a);
		logic [7:0] rb;
		master.start_c();
		master.byte_x(ab, rb);
		master.bit_x(1'b1, a);
	endtask : addr_tx

	// read of n back-to-back conversions, master naks the last lower byte
	task automatic read_tx(input int n);
		logic [7:0] rb;
		logic       a;
		int         s0;
		s0 = starts;
		addr_tx({adcr_pkg::DEV_CODE, strap, 1'b1}, a);
		check(10'(a), 10'h000, "read ack");
		check(10'(starts - s0), 10'h001, "first sample");
		for (int k = 0; k < n; k++) begin
			master.byte_x(8'hFF, rb);
			check(10'(rb), {6'h00, last_res[9:6]}, "upper byte");
			master.bit_x(1'b0, a);
			master.byte_x(8'hFF, rb);
			check(10'(rb[7:2]), 10'(last_res[5:0]), "lower byte");
			master.bit_x(k == n - 1, a);
			check(10'(starts - s0), 10'(k + 2), "next sample");
		end
		master.stop_c();
	endtask : read_tx

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up

	// main sequence
	initial begin
		logic [7:0] rb;
		logic       a;
		int         s0;
		void'($urandom(15));
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		// every strap setting, one to three conversions per read
		for (int s = 0; s < 8; s++) begin
			@(posedge mclk_i);
			strap <= 3'(s);
			@(posedge mclk_i);
			read_tx(1 + s % 3);
		end
		// presence poll, then repeated start into a read
		s0 = starts;
		addr_tx({adcr_pkg::DEV_CODE, strap, 1'b0}, a);
		check(10'(a), 10'h000, "poll ack");
		repeat (10) @(posedge mclk_i);
		check(10'(sda_line), 10'h001, "poll release");
		check(10'(starts - s0), 10'h000, "poll sample");
		read_tx(2);
		// wrong device code, then wrong straps: no ack and bus left alone
		for (int j = 0; j < 2; j++) begin
			s0 = starts;
			addr_tx(j ? {adcr_pkg::DEV_CODE, ~strap, 1'b1}
			          : {adcr_pkg::DEV_CODE ^ 4'h8, strap, 1'b1}, a);
			check(10'(a), 10'h001, "foreign nak");
			master.byte_x(8'hFF, rb);
			check(10'(rb), 10'h0FF, "foreign byte");
			check(10'(starts - s0), 10'h000, "foreign sample");
			master.stop_c();
		end
		// buffer refuses after its depth, reset in mid-run empties it
		s0 = acc;
		fill <= 1'b1;
		repeat (60) @(posedge mclk_i);
		check(10'(conv_ready_o), 10'h000, "buffer full");
		// the sample from the last read's closing bit still waits in the buffer
		check(10'(acc - s0), 10'(adcr_pkg::FIFO_DEPTH - 1), "buffer depth");
		fill   <= 1'b0;
		srst_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		check(10'(conv_ready_o), 10'h001, "buffer emptied");
		read_tx(2);
		wrap_up();
	end
endmodule : test_adcr_i2c_target
